/* File: rtl/fp8_mult_pkg.sv */
// constants and types shared by the fp8 multiplier design
package fp8_mult_pkg;

  // ----------------------------------------------------------------
  // operand format
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sign;
    logic [3:0] exponent;
    logic [2:0] fraction;
  } fp8_t;

  localparam int FP8_W = 8;
  localparam int EXP_W = 4;
  localparam int FRAC_W = 3;
  localparam logic [6:0] EXP_BIAS = 7'h07;
  localparam logic signed [6:0] EXP_MIN_S = 7'sh01;
  localparam logic signed [6:0] EXP_MAX_S = 7'sh0f;
  localparam logic [3:0] EXP_ZERO = 4'h0;
  localparam logic [7:0] NAN_CODE = 8'h80;
  localparam logic [7:0] ZERO_CODE = 8'h00;
  localparam logic [6:0] SAT_MAG = 7'h7f;

  // ----------------------------------------------------------------
  // operator inputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic load_gate_n;
    logic operand_select;
    logic half_select;
    logic [3:0] nibble;
  } ctrl_t;

  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h40;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [1:0] SEL_OP1_LO = 2'h0;
  localparam logic [1:0] SEL_OP1_HI = 2'h1;
  localparam logic [1:0] SEL_OP2_LO = 2'h2;
  localparam logic [1:0] SEL_OP2_HI = 2'h3;

endpackage : fp8_mult_pkg

/* File: rtl/pin_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  assign q_nxt = (s2_r == s3_r) ? s3_r : q_r;
  assign q_o = q_r;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

endmodule : pin_sync3
`default_nettype wire

/* File: rtl/fp8_mult_4e3f.sv */
// fp8 multiplier with nibble-loaded operand buffers
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - gate low loads nibble each clock edge
// - select pair picks operand and half written
// - operand is sign, exponent four, fraction three
// - value is two to exponent minus seven
// - zero exponent input or subnormal result gives zero
// - all-ones exponent is an ordinary finite value
// - overflow saturates to signed magnitude 480
// - sign-only pattern is nan, not zero
// - round to nearest, ties to even
// - product follows buffers without any clock

module fp8_mult_4e3f
  import fp8_mult_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic load_gate_n_i,
  input wire logic operand_select_i,
  input wire logic half_select_i,
  input wire logic [3:0] nibble_i,
  output logic [7:0] product_o
);

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  ctrl_t ctrl_pin_w;
  ctrl_t ctrl_w;
  logic [CTRL_W-1:0] ctrl_q_w;

  assign ctrl_pin_w = '{load_gate_n: load_gate_n_i, operand_select: operand_select_i,
                        half_select: half_select_i, nibble: nibble_i};

  pin_sync3 #(
    .W(CTRL_W),
    .RST_VAL(CTRL_RST)
  ) u_ctrl_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(ctrl_pin_w),
    .q_o(ctrl_q_w)
  );

  assign ctrl_w = ctrl_t'(ctrl_q_w);

  // ----------------------------------------------------------------
  // operand buffer write decode
  // ----------------------------------------------------------------
  logic load_en_w;
  logic [1:0] sel_w;
  logic wr_op1_lo_w;
  logic wr_op1_hi_w;
  logic wr_op2_lo_w;
  logic wr_op2_hi_w;

  assign load_en_w = ~ctrl_w.load_gate_n;
  assign sel_w = {ctrl_w.operand_select, ctrl_w.half_select};
  assign wr_op1_lo_w = load_en_w && (sel_w == SEL_OP1_LO);
  assign wr_op1_hi_w = load_en_w && (sel_w == SEL_OP1_HI);
  assign wr_op2_lo_w = load_en_w && (sel_w == SEL_OP2_LO);
  assign wr_op2_hi_w = load_en_w && (sel_w == SEL_OP2_HI);

  // ----------------------------------------------------------------
  // operand buffers
  // ----------------------------------------------------------------
  logic [7:0] op1_r;
  logic [7:0] op2_r;
  logic [7:0] op1_nxt;
  logic [7:0] op2_nxt;

  assign op1_nxt = wr_op1_lo_w ? {op1_r[7:4], ctrl_w.nibble} :
                   wr_op1_hi_w ? {ctrl_w.nibble, op1_r[3:0]} : op1_r;
  assign op2_nxt = wr_op2_lo_w ? {op2_r[7:4], ctrl_w.nibble} :
                   wr_op2_hi_w ? {ctrl_w.nibble, op2_r[3:0]} : op2_r;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      op1_r <= BUF_RST;
      op2_r <= BUF_RST;
    end else begin
      op1_r <= op1_nxt;
      op2_r <= op2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // operand decode and special cases
  // ----------------------------------------------------------------
  fp8_t op_a_w;
  fp8_t op_b_w;
  logic nan_in_w;
  logic zero_in_w;

  assign op_a_w = fp8_t'(op1_r);
  assign op_b_w = fp8_t'(op2_r);
  assign nan_in_w = (op1_r == NAN_CODE) || (op2_r == NAN_CODE);
  assign zero_in_w = (op_a_w.exponent == EXP_ZERO) || (op_b_w.exponent == EXP_ZERO);

  // ----------------------------------------------------------------
  // significand product and normalisation
  // ----------------------------------------------------------------
  logic res_sign_w;
  logic [3:0] sig_a_w;
  logic [3:0] sig_b_w;
  logic [7:0] sig_prod_w;
  logic norm_w;
  logic [2:0] m_pre_w;
  logic guard_w;
  logic sticky_w;

  assign res_sign_w = op_a_w.sign ^ op_b_w.sign;
  assign sig_a_w = {1'b1, op_a_w.fraction};
  assign sig_b_w = {1'b1, op_b_w.fraction};
  assign sig_prod_w = {4'h0, sig_a_w} * {4'h0, sig_b_w};
  assign norm_w = sig_prod_w[7];
  assign m_pre_w = norm_w ? sig_prod_w[6:4] : sig_prod_w[5:3];
  assign guard_w = norm_w ? sig_prod_w[3] : sig_prod_w[2];
  assign sticky_w = norm_w ? (|sig_prod_w[2:0]) : (|sig_prod_w[1:0]);

  // ----------------------------------------------------------------
  // rounding
  // ----------------------------------------------------------------
  logic rnd_up_w;
  logic [3:0] m_rnd_w;
  logic rnd_carry_w;
  logic [2:0] frac_out_w;

  assign rnd_up_w = guard_w && (sticky_w || m_pre_w[0]);
  assign m_rnd_w = {1'b0, m_pre_w} + {3'h0, rnd_up_w};
  assign rnd_carry_w = m_rnd_w[3];
  assign frac_out_w = m_rnd_w[2:0];

  // ----------------------------------------------------------------
  // exponent
  // ----------------------------------------------------------------
  logic signed [6:0] e_raw_w;
  logic signed [6:0] e_norm_w;
  logic signed [6:0] e_fin_w;
  logic underflow_w;
  logic overflow_w;

  assign e_raw_w = {3'h0, op_a_w.exponent} + {3'h0, op_b_w.exponent} - EXP_BIAS;
  assign e_norm_w = e_raw_w + {6'h00, norm_w};
  assign e_fin_w = e_norm_w + {6'h00, rnd_carry_w};
  assign underflow_w = (e_fin_w < EXP_MIN_S);
  assign overflow_w = (e_fin_w > EXP_MAX_S);

  // ----------------------------------------------------------------
  // result select
  // ----------------------------------------------------------------
  logic [7:0] res_bits_w;
  fp8_t res_w;

  assign res_bits_w = nan_in_w ? NAN_CODE :
                      zero_in_w ? ZERO_CODE :
                      underflow_w ? ZERO_CODE :
                      overflow_w ? {res_sign_w, SAT_MAG} :
                      {res_sign_w, e_fin_w[3:0], frac_out_w};
  assign res_w = fp8_t'(res_bits_w);

  // ----------------------------------------------------------------
  // output pin order
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < FP8_W; k++) begin : g_pin
      assign product_o[k] = res_bits_w[FP8_W-1-k];
    end
  endgenerate

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic past_ok_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      past_ok_r <= 1'b0;
    end else begin
      past_ok_r <= 1'b1;
    end
  end

  a_load_op1_lo: assert property (
    past_ok_r && wr_op1_lo_w |=> op1_r == {$past(op1_r[7:4]), $past(ctrl_w.nibble)}
  ) else $error("operand one low half not loaded");

  a_sel_halves: assert property (
    past_ok_r && load_en_w && sel_w == SEL_OP2_HI |=>
      op2_r[7:4] == $past(ctrl_w.nibble) && op2_r[3:0] == $past(op2_r[3:0]) && $stable(op1_r)
  ) else $error("operand two high half select wrong");

  a_sel_op1_hi: assert property (
    past_ok_r && load_en_w && sel_w == SEL_OP1_HI |=>
      op1_r[7:4] == $past(ctrl_w.nibble) && $stable(op2_r)
  ) else $error("operand one high half select wrong");

  a_gate_hold: assert property (
    past_ok_r && ctrl_w.load_gate_n |=> $stable(op1_r) && $stable(op2_r)
  ) else $error("buffer changed while gated");

  a_sign_xor: assert property (
    !nan_in_w && !zero_in_w && !underflow_w |-> product_o[0] == (op1_r[7] ^ op2_r[7])
  ) else $error("product sign wrong");

  a_exp_bias: assert property (
    !nan_in_w && !zero_in_w && !underflow_w && !overflow_w && !norm_w && !rnd_carry_w |->
      res_w.exponent == 4'(op_a_w.exponent + op_b_w.exponent - 4'h7)
  ) else $error("biased exponent wrong");

  a_zero_flush: assert property (
    !nan_in_w && (op_a_w.exponent == EXP_ZERO || underflow_w) |-> product_o == ZERO_CODE
  ) else $error("zero or subnormal not flushed");

  a_exp_ones: assert property (
    op_a_w.exponent == 4'hf && op_b_w.fraction == 3'h0 && op_b_w.exponent == EXP_BIAS[3:0] |->
      res_w.exponent == 4'hf && res_w.fraction == op_a_w.fraction
  ) else $error("all-ones exponent not finite");

  a_saturate: assert property (
    !nan_in_w && !zero_in_w && overflow_w |-> res_w == {op1_r[7] ^ op2_r[7], 7'h7f}
  ) else $error("overflow not saturated");

  a_nan_prop: assert property (
    op1_r == 8'h80 || op2_r == 8'h80 |-> res_bits_w == 8'h80
  ) else $error("nan not propagated");

  a_round_tie: assert property (
    !nan_in_w && !zero_in_w && !underflow_w && !overflow_w && guard_w && !sticky_w |->
      res_w.fraction[0] == 1'b0
  ) else $error("tie not rounded to even");

  a_track_bufs: assert property (
    past_ok_r && $stable(op1_r) && $stable(op2_r) |-> $stable(product_o)
  ) else $error("product changed without buffer change");

  a_pin_order: assert property (
    product_o[4:1] == {res_w.exponent[0], res_w.exponent[1], res_w.exponent[2],
                       res_w.exponent[3]} && product_o[7] == res_w.fraction[0]
  ) else $error("output pin order wrong");

  a_sel_op1_keep: assert property (
    past_ok_r && wr_op1_lo_w |=> $stable(op2_r)
  ) else $error("operand two changed on operand one write");

  a_sel_op2_lo: assert property (
    past_ok_r && load_en_w && sel_w == SEL_OP2_LO |=>
      op2_r == {$past(op2_r[7:4]), $past(ctrl_w.nibble)} && $stable(op1_r)
  ) else $error("operand two low half select wrong");

  a_op1_hi_keep: assert property (
    past_ok_r && wr_op1_hi_w |=> op1_r[3:0] == $past(op1_r[3:0])
  ) else $error("operand one low half disturbed");

  a_one_target: assert property (
    $onehot0({wr_op1_lo_w, wr_op1_hi_w, wr_op2_lo_w, wr_op2_hi_w})
  ) else $error("more than one buffer half written");

  a_gate_no_write: assert property (
    ctrl_w.load_gate_n |-> !(wr_op1_lo_w || wr_op1_hi_w || wr_op2_lo_w || wr_op2_hi_w)
  ) else $error("write decoded while gated");

  a_load_open: assert property (
    !ctrl_w.load_gate_n |-> wr_op1_lo_w || wr_op1_hi_w || wr_op2_lo_w || wr_op2_hi_w
  ) else $error("no write decoded while gate open");

  a_zero_in_b: assert property (
    !nan_in_w && op_b_w.exponent == EXP_ZERO |-> product_o == ZERO_CODE
  ) else $error("zero operand two not flushed");

  a_no_neg_zero: assert property (
    !nan_in_w |-> res_bits_w != NAN_CODE
  ) else $error("nan pattern without nan input");

  a_exact_frac: assert property (
    !nan_in_w && !zero_in_w && !underflow_w && !overflow_w && !guard_w |->
      res_w.fraction == m_pre_w
  ) else $error("exact fraction altered");

  a_max_finite: assert property (
    !nan_in_w && !zero_in_w && e_fin_w == EXP_MAX_S |-> res_w.exponent == 4'hf
  ) else $error("top exponent not kept finite");

  a_sign_pin: assert property (
    product_o[0] == res_w.sign &&
      product_o[6:5] == {res_w.fraction[1], res_w.fraction[2]}
  ) else $error("sign or fraction pin order wrong");

  c_load_op2_hi: cover property (wr_op2_hi_w ##1 wr_op2_hi_w);
  c_overflow: cover property (!nan_in_w && !zero_in_w && overflow_w);
  c_round_tie: cover property (!zero_in_w && guard_w && !sticky_w && m_pre_w[0]);
  c_nan_input: cover property (nan_in_w);
  c_underflow: cover property (!zero_in_w && underflow_w);

endmodule : fp8_mult_4e3f
`default_nettype wire

/* File: verif/switch_panel.sv */
// operator switch panel model for the fp8 multiplier
`timescale 1ns/100ps
`default_nettype none

module switch_panel
  import fp8_mult_pkg::*;
(
  input wire logic ref_clk_i,
  output var logic load_gate_n_o,
  output var logic operand_select_o,
  output var logic half_select_o,
  output var logic [3:0] nibble_o
);
  // ----------------------------------------
  // switch positions, moved at falling edges
  // ----------------------------------------
  initial begin
    load_gate_n_o = 1'b1;
    operand_select_o = 1'b0;
    half_select_o = 1'b0;
    nibble_o = 4'h0;
  end

  task automatic set_pins(input logic gate_n, input logic [1:0] sel, input logic [3:0] nib);
    @(negedge ref_clk_i);
    load_gate_n_o = gate_n;
    {operand_select_o, half_select_o} = sel;
    nibble_o = nib;
  endtask : set_pins

  // selects settle with gate closed, then gate opens long enough to pass the pin filter
  task automatic load(input logic [1:0] sel, input logic [3:0] nib);
    set_pins(1'b1, sel, nib);
    repeat (4) @(negedge ref_clk_i);
    set_pins(1'b0, sel, nib);
    repeat (6) @(negedge ref_clk_i);
    set_pins(1'b1, sel, nib);
    repeat (6) @(negedge ref_clk_i);
  endtask : load
endmodule : switch_panel
`default_nettype wire

/* File: verif/fp8_mult_4e3f_test.sv */
// self-checking bench for the fp8 multiplier
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end

module fp8_mult_4e3f_test
  import fp8_mult_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic gate_n, op_sel, half_sel;
  logic [3:0] nibble;
  logic [7:0] product;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ----------------------------------------
  // clock, instances, watchdog
  // ----------------------------------------
  always #12.5 ref_clk_i = ~ref_clk_i;

  switch_panel panel (.ref_clk_i(ref_clk_i), .load_gate_n_o(gate_n),
    .operand_select_o(op_sel), .half_select_o(half_sel), .nibble_o(nibble));

  fp8_mult_4e3f dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .load_gate_n_i(gate_n),
    .operand_select_i(op_sel), .half_select_i(half_sel), .nibble_i(nibble),
    .product_o(product));

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // reference product and pin order
  // ----------------------------------------
  function automatic logic [7:0] ref_mul(input logic [7:0] a, input logic [7:0] b);
    int e, p, keep, rem, half;
    if (a == 8'h80 || b == 8'h80) return 8'h80;
    if (a[6:3] == 4'h0 || b[6:3] == 4'h0) return 8'h00;
    e = int'(a[6:3]) + int'(b[6:3]) - 7;
    p = int'({1'b1, a[2:0]}) * int'({1'b1, b[2:0]});
    if (p >= 128) begin
      e++;
      keep = p >> 4;
      rem = p & 15;
      half = 8;
    end else begin
      keep = p >> 3;
      rem = p & 7;
      half = 4;
    end
    if (rem > half || (rem == half && keep[0])) keep++;
    if (keep == 16) begin
      keep = 8;
      e++;
    end
    if (e < 1) return 8'h00;
    if (e > 15) return {a[7] ^ b[7], 7'h7f};
    return {a[7] ^ b[7], e[3:0], keep[2:0]};
  endfunction : ref_mul

  function automatic logic [7:0] to_pins(input logic [7:0] f);
    return {<<{f}};
  endfunction : to_pins

  // halves loaded out of order; each select code used once per pair
  task automatic run_vector(input logic [7:0] a, input logic [7:0] b);
    panel.load(2'h1, a[7:4]);
    panel.load(2'h2, b[3:0]);
    panel.load(2'h0, a[3:0]);
    panel.load(2'h3, b[7:4]);
    `CHK(product, to_pins(ref_mul(a, b)))
  endtask : run_vector

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic check_normal();
    run_vector(8'h38, 8'h38);
    run_vector(8'h40, 8'hc4);
    run_vector(8'hb3, 8'hcd);
  endtask : check_normal

  task automatic check_specials();
    run_vector(8'h05, 8'h40);
    run_vector(8'h85, 8'h40);
    run_vector(8'h08, 8'h08);
    run_vector(8'h80, 8'h38);
    run_vector(8'h00, 8'h80);
    run_vector(8'h78, 8'h38);
    run_vector(8'h77, 8'h77);
    run_vector(8'hf7, 8'h77);
  endtask : check_specials

  task automatic check_rounding();
    run_vector(8'h3a, 8'h3a);
    run_vector(8'h39, 8'h3c);
    run_vector(8'h39, 8'h3e);
  endtask : check_rounding

  task automatic check_hold();
    logic [7:0] held;
    run_vector(8'h4b, 8'h36);
    held = product;
    for (int s = 0; s < 4; s++) begin
      panel.set_pins(1'b1, s[1:0], 4'hf - s[3:0]);
      repeat (8) @(negedge ref_clk_i);
      `CHK(product, held)
    end
    panel.set_pins(1'b1, 2'h3, 4'h0);
    repeat (8) @(negedge ref_clk_i);
    `CHK(product, to_pins(ref_mul(8'h4b, 8'h36)))
  endtask : check_hold

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    `CHK(product, 8'h00)
    check_normal();
    check_specials();
    check_rounding();
    check_hold();
    wrap_up();
  end
endmodule : fp8_mult_4e3f_test
`default_nettype wire
